//--- mmt_defines.svh
// Purpose: Constants for the multi-mode timer block
// Assumes: APB slave, 32-bit data, six 16-bit timers
// Notes: Offsets are byte addresses
//
// What this block does
// - A counter read during counting returns the live counter value.
// - An event-mode read at the reload instant returns all ones on underflow, zeros on overflow.
// - In timer mode a read at the reload instant returns all ones.
// - A value written to a halted timer reads back unchanged before counting begins.
// - Clearing start in one-shot mode halts the counter and copies the reload value into it.
// - Clearing start in one-shot mode drives the timer output low.
// - Clearing start in one-shot mode sets the timer's request bit.
// - Selecting one-shot mode after reset or from timer or event mode sets the request bit.
// - Selecting PWM mode after reset or from timer or event mode sets the request bit.
// - Clearing start in PWM mode halts counting; a high output goes low and sets the request.
// - Clearing start in PWM mode with a low output leaves it low and raises no request.
// - Changing the measurement select bit while measuring sets the request bit.
// - The first measurement edge after start loads an undefined value and raises no request.
`ifndef MMT_DEFINES_SVH
`define MMT_DEFINES_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define MMT_NUM 6
`define MMT_W 16

// ----------------------------------------
// Register map
// ----------------------------------------
`define MMT_ADDR_W 8
`define MMT_GLOBAL_BLK 3'h6
`define MMT_REG_CTRL 2'h0
`define MMT_REG_CNT 2'h1
`define MMT_REG_START 2'h0
`define MMT_REG_STAT 2'h1
`define MMT_REG_MASK 2'h2

// ----------------------------------------
// Control fields
// ----------------------------------------
`define MMT_CTRL_MODE_LO 0
`define MMT_CTRL_MODE_HI 2
`define MMT_CTRL_MSEL 3
`define MMT_CTRL_FRUN 4
`define MMT_CTRL_UP 5

// ----------------------------------------
// Values
// ----------------------------------------
`define MMT_ONES 16'hFFFF
`define MMT_ZERO 16'h0000
`define MMT_RST_CNT 16'h0000

`endif

//--- mmt_pkg.sv
// Purpose: Types for the multi-mode timer block
// Assumes: Nothing
// Notes: Mode encoding follows enum order
package mmt_pkg;
    typedef enum logic [2:0] {MMT_TIMER, MMT_EVENT, MMT_ONESHOT, MMT_PWM, MMT_MEASURE} mmt_mode_e;
endpackage : mmt_pkg

//--- mmt_timer.sv
// Purpose: Six 16-bit multi-mode timers behind an APB slave
// Assumes: Timer 0 has no measurement mode; timers 1..5 do
// Notes: Zero-wait APB; pin inputs pass three flip-flops
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "mmt_defines.svh"

module mmt_timer
    import mmt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`MMT_NUM-1:0] aux_timer_io_pin_in,
    output logic [`MMT_NUM-1:0] aux_timer_io_pin_out,
    output logic [`MMT_NUM-1:0] aux_timer_io_pin_oe,
    output logic irq
);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic [2:0] blk;
    logic [1:0] reg_sel;
    logic mapped;
    logic acc;
    logic wr_en;
    logic rd_stat;
    logic wr_start;
    logic wr_mask;
    logic [`MMT_NUM-1:0] wr_ctrl;
    logic [`MMT_NUM-1:0] wr_cnt;
    logic [`MMT_NUM-1:0] run_a;
    logic [`MMT_NUM-1:0] set_a;
    logic [`MMT_NUM-1:0] stat;
    logic [`MMT_NUM-1:0] mask;
    logic [`MMT_W-1:0] rdv_a [`MMT_NUM];
    logic [5:0] ctrl_a [`MMT_NUM];
    logic [31:0] next_rdata;

    assign blk = paddr[6:4];
    assign reg_sel = paddr[3:2];
    assign mapped = (paddr[31:7] == 25'h0000000) && (paddr[1:0] == 2'h0)
        && ((blk < `MMT_GLOBAL_BLK) ? (reg_sel <= `MMT_REG_CNT)
        : ((blk == `MMT_GLOBAL_BLK) && (reg_sel <= `MMT_REG_MASK)));
    assign pready = 1'b1;
    assign acc = psel && penable;
    assign pslverr = acc && !mapped;
    assign wr_en = acc && pwrite && mapped;
    assign rd_stat = acc && !pwrite && (blk == `MMT_GLOBAL_BLK) && (reg_sel == `MMT_REG_STAT);
    assign wr_start = wr_en && (blk == `MMT_GLOBAL_BLK) && (reg_sel == `MMT_REG_START);
    assign wr_mask = wr_en && (blk == `MMT_GLOBAL_BLK) && (reg_sel == `MMT_REG_MASK);

    // ----------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (blk < `MMT_GLOBAL_BLK)
        begin
            if (reg_sel == `MMT_REG_CTRL)
                next_rdata = {26'h0000000, ctrl_a[blk]};
            else
                next_rdata = {16'h0000, rdv_a[blk]};
        end
        else if (blk == `MMT_GLOBAL_BLK)
        begin
            case (reg_sel)
                `MMT_REG_START: next_rdata = {26'h0000000, run_a};
                `MMT_REG_STAT: next_rdata = {26'h0000000, stat};
                `MMT_REG_MASK: next_rdata = {26'h0000000, mask};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite && mapped)
            prdata <= next_rdata;
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stat <= 6'h00;
        else
            stat <= (rd_stat ? 6'h00 : stat) | set_a;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask <= 6'h00;
        else if (wr_mask)
            mask <= pwdata[`MMT_NUM-1:0];
    end

    assign irq = |(stat & mask);

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    genvar gi;
    for (gi = 0; gi < `MMT_NUM; gi++)
    begin : g_tmr
        logic [2:0] sync;
        logic lvl;
        logic ev_rise;
        logic ev_any;
        logic meas_edge;
        logic [`MMT_W-1:0] cnt;
        logic [`MMT_W-1:0] rld;
        mmt_mode_e mode;
        mmt_mode_e next_mode;
        logic msel;
        logic frun;
        logic up;
        logic run;
        logic out_q;
        logic first;
        logic go;
        logic stop_evt;
        logic zero;
        logic ev_wrap;
        logic rl_now;
        logic os_done;
        logic pwm_flip;

        assign wr_ctrl[gi] = wr_en && (blk == gi) && (reg_sel == `MMT_REG_CTRL);
        assign wr_cnt[gi] = wr_en && (blk == gi) && (reg_sel == `MMT_REG_CNT);

        // Input synchroniser and filter
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                sync <= 3'h0;
                lvl <= 1'b0;
            end
            else
            begin
                sync <= {sync[1:0], aux_timer_io_pin_in[gi]};
                if (sync[1] == sync[2])
                    lvl <= sync[2];
            end
        end

        assign ev_any = (sync[1] == sync[2]) && (sync[2] != lvl);
        assign ev_rise = ev_any && sync[2];
        assign meas_edge = msel ? ev_any : ev_rise;

        // Mode decode, measurement not on timer 0
        always_comb
        begin
            next_mode = mmt_mode_e'(pwdata[`MMT_CTRL_MODE_HI:`MMT_CTRL_MODE_LO]);
            if ((next_mode == MMT_MEASURE && gi == 0) || next_mode > MMT_MEASURE)
                next_mode = MMT_TIMER;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                mode <= MMT_TIMER;
                msel <= 1'b0;
                frun <= 1'b0;
                up <= 1'b0;
            end
            else if (wr_ctrl[gi])
            begin
                mode <= next_mode;
                msel <= pwdata[`MMT_CTRL_MSEL];
                frun <= pwdata[`MMT_CTRL_FRUN];
                up <= pwdata[`MMT_CTRL_UP];
            end
        end

        assign ctrl_a[gi] = {up, frun, msel, mode};

        // Start and stop
        assign go = wr_start && pwdata[gi] && !run;
        assign stop_evt = wr_start && !pwdata[gi] && run;
        assign zero = (cnt == `MMT_ZERO);
        assign ev_wrap = up ? (cnt == `MMT_ONES) : zero;
        assign rl_now = run && !frun && ((mode == MMT_TIMER && zero)
            || (mode == MMT_EVENT && ev_rise && ev_wrap));
        assign os_done = run && !stop_evt && mode == MMT_ONESHOT && zero;
        assign pwm_flip = run && !stop_evt && mode == MMT_PWM && zero;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                run <= 1'b0;
            else if (wr_start)
                run <= pwdata[gi];
            else if (os_done)
                run <= 1'b0;
        end

        assign run_a[gi] = run;

        // Counter and reload
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt <= `MMT_RST_CNT;
                rld <= `MMT_RST_CNT;
            end
            else if (wr_cnt[gi])
            begin
                rld <= pwdata[`MMT_W-1:0];
                if (!run)
                    cnt <= pwdata[`MMT_W-1:0];
            end
            else if (stop_evt && mode == MMT_ONESHOT)
                cnt <= rld;
            else if (go && (mode == MMT_ONESHOT || mode == MMT_PWM))
                cnt <= rld;
            else if (go && mode == MMT_MEASURE)
                cnt <= `MMT_ZERO;
            else if (run && !stop_evt)
            begin
                case (mode)
                    MMT_TIMER: cnt <= zero ? (frun ? `MMT_ONES : rld) : cnt - 16'h0001;
                    MMT_EVENT:
                    begin
                        if (ev_rise && up)
                            cnt <= ev_wrap ? (frun ? `MMT_ZERO : rld) : cnt + 16'h0001;
                        else if (ev_rise)
                            cnt <= ev_wrap ? (frun ? `MMT_ONES : rld) : cnt - 16'h0001;
                    end
                    MMT_ONESHOT: cnt <= zero ? rld : cnt - 16'h0001;
                    MMT_PWM: cnt <= zero ? (out_q ? ~rld : rld) : cnt - 16'h0001;
                    MMT_MEASURE:
                    begin
                        if (meas_edge)
                        begin
                            rld <= cnt;
                            cnt <= `MMT_ZERO;
                        end
                        else
                            cnt <= cnt + 16'h0001;
                    end
                    default: cnt <= cnt;
                endcase
            end
        end

        // Readback at reload instant
        assign rdv_a[gi] = !rl_now ? cnt
            : ((mode == MMT_EVENT && up) ? `MMT_ZERO : `MMT_ONES);

        // First measurement edge tracking
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                first <= 1'b0;
            else if (go)
                first <= 1'b1;
            else if (run && mode == MMT_MEASURE && meas_edge)
                first <= 1'b0;
        end

        // Output pin
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                out_q <= 1'b0;
            else if (stop_evt)
                out_q <= 1'b0;
            else if (go && (mode == MMT_ONESHOT || mode == MMT_PWM))
                out_q <= 1'b1;
            else if (os_done)
                out_q <= 1'b0;
            else if (pwm_flip)
                out_q <= !out_q;
            else if (mode != MMT_ONESHOT && mode != MMT_PWM)
                out_q <= 1'b0;
        end

        assign aux_timer_io_pin_out[gi] = out_q;
        assign aux_timer_io_pin_oe[gi] = (mode == MMT_ONESHOT || mode == MMT_PWM);

        // Request sources
        assign set_a[gi] =
            (wr_ctrl[gi] && (next_mode == MMT_ONESHOT || next_mode == MMT_PWM)
                && (mode == MMT_TIMER || mode == MMT_EVENT))
            || (wr_ctrl[gi] && run && mode == MMT_MEASURE && next_mode == MMT_MEASURE
                && pwdata[`MMT_CTRL_MSEL] != msel)
            || (stop_evt && mode == MMT_ONESHOT)
            || (stop_evt && mode == MMT_PWM && out_q)
            || rl_now
            || os_done
            || (pwm_flip && out_q)
            || (run && mode == MMT_MEASURE && meas_edge && !first);
    end

endmodule : mmt_timer

//--- mmt_properties.sv
// Purpose: Port assertions for mmt_timer
// Assumes: Zero-wait APB, timer 0 at offset 0
// Notes: Bind at the foot
module mmt_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] aux_timer_io_pin_out,
    input wire logic [5:0] aux_timer_io_pin_oe,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic acc;
    logic stop0;
    logic [5:0] msk;
    assign acc = psel && penable;
    assign stop0 = acc && pwrite && paddr[7:0] == 8'h60 && !pwdata[0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow of the mask register
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            msk <= 6'h00;
        else if (acc && pwrite && paddr[7:0] == 8'h68)
            msk <= pwdata[5:0];
    AST_ZERO_WAIT: assert property (acc |-> pready)
        else $error("pready low in access");
    AST_UNMAPPED: assert property (acc && paddr[7:0] == 8'h6C |-> pslverr)
        else $error("no error on unmapped");
    AST_ERR_IDLE: assert property (!acc |-> !pslverr)
        else $error("error outside access");
    AST_RDATA_HOLD: assert property (
        $changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without read");
    AST_MODE_PIN: assert property ($changed(aux_timer_io_pin_oe) |-> $past(acc && pwrite))
        else $error("pin enable moved without write");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(acc))
        else $error("irq fell without access");
    AST_STOP_LOW: assert property (
        stop0 && aux_timer_io_pin_oe[0] |=> !aux_timer_io_pin_out[0])
        else $error("output not low after stop");
    AST_STOP_REQ: assert property (
        stop0 && aux_timer_io_pin_oe[0] && aux_timer_io_pin_out[0] && msk[0] |=> irq)
        else $error("no request after stop");
    AST_MODE_REQ: assert property (
        acc && pwrite && paddr[7:0] == 8'h00 && pwdata[2:1] == 2'b01
        && !aux_timer_io_pin_oe[0] && msk[0] |=> irq)
        else $error("no request after mode change");
endmodule : mmt_properties

bind mmt_timer mmt_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .aux_timer_io_pin_out, .aux_timer_io_pin_oe, .irq);

//--- mmt_pin_model.sv
// Purpose: Far-side pin model for mmt_timer
// Assumes: Pins are two-way
// Notes: Source pulses last four clocks
module mmt_pin_model (
    input wire logic pclk,
    input wire logic [5:0] oe,
    input wire logic [5:0] pout,
    output wire logic [5:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] drv = 6'h00;
    // Timer drives when enabled, else the source
    assign pin_in = (oe & pout) | (~oe & drv);
    // Longer than the three-flop filter
    task automatic pulse(input int i);
        drv[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        drv[i] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse
endmodule : mmt_pin_model

//--- mmt_timer_tb.sv
// Purpose: Self-checking bench for mmt_timer
// Assumes: Zero-wait APB slave
// Notes: Pins through mmt_pin_model
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) \
    begin failures++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module mmt_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r;
    logic pready, pslverr, irq, err;
    logic [5:0] pin_in, pout, oe;
    int failures = 0;
    int cmp_count = 0;
    int md[6] = '{2, 3, 0, 1, 3, 2};
    logic ex[6] = '{1, 0, 0, 0, 1, 0};
    always #20 pclk = ~pclk;
    mmt_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .aux_timer_io_pin_in(pin_in), .aux_timer_io_pin_out(pout),
        .aux_timer_io_pin_oe(oe), .irq);
    mmt_pin_model pins (.pclk, .oe, .pout, .pin_in);
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {24'h000000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask : apb
    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 8'h64, 0);
        `CHK("stat", 32'h0, r)
        apb(0, 8'h6C, 0);
        `CHK("slverr", 1'b1, err)
        for (int i = 0; i < 6; i++)
        begin
            apb(1, 8'(i * 16 + 4), 32'hA500 + i);
            apb(0, 8'(i * 16 + 4), 0);
            `CHK("count", 32'hA500 + i, r)
        end
        apb(1, 8'h68, 1);
        for (int k = 0; k < 6; k++)
        begin
            apb(1, 8'h00, md[k]);
            `CHK("irq", ex[k], irq)
            apb(0, 8'h64, 0);
            `CHK("req", ex[k], r[0])
        end
        apb(1, 8'h68, 0);
        apb(1, 8'h00, 0);
        apb(1, 8'h00, 3);
        `CHK("masked", 1'b0, irq)
        apb(1, 8'h68, 1);
        `CHK("unmasked", 1'b1, irq)
        apb(0, 8'h64, 0);
        `CHK("cleared", 1'b0, irq)
        apb(1, 8'h00, 2);
        apb(1, 8'h04, 32'h200);
        apb(1, 8'h60, 1);
        repeat (5) @(posedge pclk);
        `CHK("os out", 2'b11, {oe[0], pout[0]})
        apb(0, 8'h04, 0);
        `CHK("live", 1'b1, r[15:0] < 16'h0200)
        apb(0, 8'h64, 0);
        apb(1, 8'h60, 0);
        `CHK("os stop", 1'b0, pout[0])
        apb(0, 8'h64, 0);
        `CHK("os req", 1'b1, r[0])
        apb(0, 8'h04, 0);
        `CHK("os reload", 32'h200, r)
        apb(1, 8'h00, 3);
        apb(1, 8'h04, 32'h40);
        apb(1, 8'h60, 1);
        repeat (5) @(posedge pclk);
        apb(0, 8'h64, 0);
        `CHK("pwm high", 1'b1, pout[0])
        apb(1, 8'h60, 0);
        `CHK("pwm stop", 1'b0, pout[0])
        apb(0, 8'h64, 0);
        `CHK("pwm req", 1'b1, r[0])
        apb(1, 8'h04, 0);
        apb(1, 8'h60, 1);
        repeat (10) @(posedge pclk);
        apb(0, 8'h64, 0);
        apb(1, 8'h60, 0);
        `CHK("pwm low", 1'b0, pout[0])
        apb(0, 8'h64, 0);
        `CHK("pwm no req", 1'b0, r[0])
        apb(1, 8'h14, 0);
        apb(1, 8'h60, 2);
        repeat (3) @(posedge pclk);
        apb(0, 8'h14, 0);
        `CHK("reload read", 32'hFFFF, r)
        apb(1, 8'h20, 32'h11);
        apb(1, 8'h24, 32'h10);
        apb(1, 8'h60, 4);
        pins.pulse(2);
        pins.pulse(2);
        apb(0, 8'h24, 0);
        `CHK("events", 32'h0E, r)
        apb(1, 8'h60, 0);
        apb(1, 8'h24, 32'h10);
        apb(1, 8'h10, 32'h4);
        apb(1, 8'h60, 2);
        apb(0, 8'h64, 0);
        pins.pulse(1);
        apb(0, 8'h64, 0);
        `CHK("first edge", 1'b0, r[1])
        apb(1, 8'h10, 32'hC);
        apb(0, 8'h64, 0);
        `CHK("msel req", 1'b1, r[1])
        pins.pulse(1);
        apb(0, 8'h64, 0);
        `CHK("next edge", 1'b1, r[1])
        // Read lands on the wrap cycle of a non-free-running event count
        for (int u = 0; u < 2; u++)
        begin
            apb(1, 8'h20, u ? 32'h21 : 32'h01);
            apb(1, 8'h24, u ? 32'hFFFF : 32'h0);
            apb(1, 8'h60, 4);
            fork
                pins.pulse(2);
                begin
                    repeat (3) @(posedge pclk);
                    apb(0, 8'h24, 0);
                end
            join
            `CHK("wrap read", u ? 32'h0 : 32'hFFFF, r)
            apb(1, 8'h60, 0);
        end
        give_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge pclk);
        failures++;
        give_verdict();
    end
endmodule : mmt_timer_tb
